// ===== include/ihb_pkg.sv
// Shared constants, register selects and decode helpers of the I/O window bridge
`default_nettype none

package ihb_pkg;

  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int SA_W = 3;

  // Register select taken from the two upper window address lines {SA2, SA1}
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_POINTER = 2'h2;
  localparam logic [1:0] SEL_DATA_FIXED = 2'h3;

  // Position of the byte selector and of the register select in the window address
  localparam int SA_BYTE_BIT = 0;
  localparam int SA_SEL_LSB = 1;

  // Strobe level meaning a write
  localparam logic WR_N_WRITE = 1'h0;

  // Reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] POINTER_RESET = 16'h0000;
  localparam logic [15:0] MEM_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Word store depth; the pointer's low bits index it
  localparam int MEM_IDX_W = 4;
  localparam int MEM_DEPTH = 16;
  localparam logic [15:0] PTR_STEP = 16'h0001;

  typedef logic [1:0] ihb_sel_t;

  function automatic ihb_sel_t ihb_reg_sel(input logic [SA_W-1:0] sa);
    ihb_reg_sel = sa[SA_SEL_LSB +: 2];
  endfunction : ihb_reg_sel

  function automatic logic ihb_is_high(input logic [SA_W-1:0] sa);
    ihb_is_high = sa[SA_BYTE_BIT];
  endfunction : ihb_is_high

  function automatic logic [7:0] ihb_byte(input logic [15:0] word, input logic hi);
    ihb_byte = hi ? word[15:8] : word[7:0];
  endfunction : ihb_byte

  function automatic logic [MEM_IDX_W-1:0] ihb_mem_index(input logic [15:0] ptr);
    ihb_mem_index = ptr[MEM_IDX_W-1:0];
  endfunction : ihb_mem_index

endpackage : ihb_pkg

`default_nettype wire

// ===== include/ihb_if.sv
// Byte-wide I/O window between the bus host end and the host port end
`timescale 1ns/1ps
`default_nettype none

interface ihb_if;
  import ihb_pkg::*;

  logic io_req;
  logic io_wr_n;
  logic [SA_W-1:0] sa;
  logic [BYTE_W-1:0] wdata;
  logic io_ack;
  logic [BYTE_W-1:0] rdata;

  modport host (
    output io_req,
    output io_wr_n,
    output sa,
    output wdata,
    input io_ack,
    input rdata
  );

  modport dev (
    input io_req,
    input io_wr_n,
    input sa,
    input wdata,
    output io_ack,
    output rdata
  );

endinterface : ihb_if

`default_nettype wire

// ===== logic/ihb_device_end.sv
// Host port end: decodes byte cycles of the I/O window onto control, pointer and word store
//
// How it works
// - Host reaches memory only via pointer then data
// - Host moves each word as two byte cycles
// - Strobe low writes, strobe high reads
// - SA2=0, SA1=0 selects the control register
// - SA0 picks byte: 0 low, 1 high
// - SA2=1, SA1=0 selects pointer, readable and writable
// - Auto alias write: increment pointer, then store
// - Auto alias read: return byte, then increment
// - Fixed alias write stores, pointer unchanged
// - Fixed alias read returns byte, pointer unchanged
`timescale 1ns/1ps
`default_nettype none

module ihb_device_end (
  input wire logic core_clk,
  input wire logic rst,
  ihb_if.dev port,
  input wire logic [ihb_pkg::MEM_IDX_W-1:0] core_rd_index,
  output logic [ihb_pkg::WORD_W-1:0] core_rd_data,
  output logic [ihb_pkg::WORD_W-1:0] control_word,
  output logic [ihb_pkg::WORD_W-1:0] pointer_word,
  output logic word_stored
);
  import ihb_pkg::*;

  // Register group
  logic [WORD_W-1:0] control;
  logic [WORD_W-1:0] pointer;
  logic [BYTE_W-1:0] low_latch;
  logic [WORD_W-1:0] next_control;
  logic [WORD_W-1:0] next_pointer;
  logic [BYTE_W-1:0] next_low_latch;

  // Word store group
  logic [WORD_W-1:0] mem [MEM_DEPTH];
  logic [WORD_W-1:0] next_mem [MEM_DEPTH];
  logic stored;
  logic next_stored;

  // Answer group
  logic ack;
  logic [BYTE_W-1:0] rdata;
  logic [WORD_W-1:0] core_data;
  logic next_ack;
  logic [BYTE_W-1:0] next_rdata;
  logic [WORD_W-1:0] next_core_data;

  // Decoded cycle
  logic cyc_wr;
  logic cyc_rd;
  logic cyc_hi;
  ihb_sel_t cyc_sel;
  logic [WORD_W-1:0] ptr_inc;
  logic [MEM_IDX_W-1:0] cur_idx;
  logic [MEM_IDX_W-1:0] inc_idx;

  always_comb begin
    cyc_wr = port.io_req && (port.io_wr_n == WR_N_WRITE);
    cyc_rd = port.io_req && (port.io_wr_n != WR_N_WRITE);
    cyc_hi = ihb_is_high(port.sa);
    cyc_sel = ihb_reg_sel(port.sa);
    ptr_inc = pointer + PTR_STEP;
    cur_idx = ihb_mem_index(pointer);
    inc_idx = ihb_mem_index(ptr_inc);
  end

  // Control and pointer registers, low byte holding latch
  always_comb begin
    next_control = control;
    next_pointer = pointer;
    next_low_latch = low_latch;
    if (cyc_wr) begin
      case (cyc_sel)
        SEL_CONTROL: begin
          // Each byte lands on its own, so a half-written control word is visible
          if (cyc_hi) begin
            next_control[15:8] = port.wdata;
          end else begin
            next_control[7:0] = port.wdata;
          end
        end
        SEL_POINTER: begin
          if (cyc_hi) begin
            next_pointer[15:8] = port.wdata;
          end else begin
            next_pointer[7:0] = port.wdata;
          end
        end
        SEL_DATA_INC: begin
          if (cyc_hi) begin
            next_pointer = ptr_inc;
          end else begin
            next_low_latch = port.wdata;
          end
        end
        SEL_DATA_FIXED: begin
          if (!cyc_hi) begin
            next_low_latch = port.wdata;
          end
        end
        default: begin
          next_control = control;
        end
      endcase
    end else if (cyc_rd) begin
      // Auto alias reads move the pointer only after the high byte left the store
      if ((cyc_sel == SEL_DATA_INC) && cyc_hi) begin
        next_pointer = ptr_inc;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control <= CONTROL_RESET;
      pointer <= POINTER_RESET;
      low_latch <= BYTE_RESET;
    end else begin
      control <= next_control;
      pointer <= next_pointer;
      low_latch <= next_low_latch;
    end
  end

  // Word store: a word is written whole when its high byte arrives, so the
  // core never sees a word with one new byte and one stale byte
  always_comb begin
    next_mem = mem;
    next_stored = 1'b0;
    if (cyc_wr && cyc_hi) begin
      case (cyc_sel)
        SEL_DATA_INC: begin
          next_mem[inc_idx] = {port.wdata, low_latch};
          next_stored = 1'b1;
        end
        SEL_DATA_FIXED: begin
          next_mem[cur_idx] = {port.wdata, low_latch};
          next_stored = 1'b1;
        end
        default: begin
          next_stored = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_RESET;
      end
      stored <= 1'b0;
    end else begin
      mem <= next_mem;
      stored <= next_stored;
    end
  end

  // Answers: every cycle is acknowledged one clock later, reads with data
  always_comb begin
    next_ack = port.io_req;
    next_rdata = rdata;
    next_core_data = mem[core_rd_index];
    if (cyc_rd) begin
      case (cyc_sel)
        SEL_CONTROL: begin
          next_rdata = ihb_byte(control, cyc_hi);
        end
        SEL_POINTER: begin
          next_rdata = ihb_byte(pointer, cyc_hi);
        end
        SEL_DATA_INC: begin
          next_rdata = ihb_byte(mem[cur_idx], cyc_hi);
        end
        SEL_DATA_FIXED: begin
          next_rdata = ihb_byte(mem[cur_idx], cyc_hi);
        end
        default: begin
          next_rdata = BYTE_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      rdata <= BYTE_RESET;
      core_data <= MEM_RESET;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      core_data <= next_core_data;
    end
  end

  assign port.io_ack = ack;
  assign port.rdata = rdata;
  assign core_rd_data = core_data;
  assign control_word = control;
  assign pointer_word = pointer;
  assign word_stored = stored;

endmodule : ihb_device_end

`default_nettype wire

// ===== logic/ihb_host_end.sv
// Bus host end: turns 16-bit register commands into two byte cycles on the I/O window
`timescale 1ns/1ps
`default_nettype none

module ihb_host_end (
  input wire logic core_clk,
  input wire logic rst,
  ihb_if.host port,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire ihb_pkg::ihb_sel_t cmd_sel,
  input wire logic [ihb_pkg::WORD_W-1:0] cmd_wdata,
  output logic cmd_ready,
  output logic resp_valid,
  output logic [ihb_pkg::WORD_W-1:0] resp_data
);
  import ihb_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LO_WAIT = 3'b010,
    ST_HI_WAIT = 3'b100
  } ihb_host_state_e;

  ihb_host_state_e state;
  ihb_host_state_e next_state;
  logic req;
  logic wr_n;
  logic [SA_W-1:0] sa;
  logic [BYTE_W-1:0] wdata;
  logic [BYTE_W-1:0] hi_hold;
  logic [BYTE_W-1:0] lo_read;
  logic ready;
  logic rvalid;
  logic [WORD_W-1:0] rword;
  logic next_req;
  logic next_wr_n;
  logic [SA_W-1:0] next_sa;
  logic [BYTE_W-1:0] next_wdata;
  logic [BYTE_W-1:0] next_hi_hold;
  logic [BYTE_W-1:0] next_lo_read;
  logic next_ready;
  logic next_rvalid;
  logic [WORD_W-1:0] next_rword;

  always_comb begin
    next_state = state;
    next_req = 1'b0;
    next_wr_n = wr_n;
    next_sa = sa;
    next_wdata = wdata;
    next_hi_hold = hi_hold;
    next_lo_read = lo_read;
    next_ready = ready;
    next_rvalid = 1'b0;
    next_rword = rword;
    case (state)
      ST_IDLE: begin
        if (cmd_valid && ready) begin
          // Low byte first; the high byte is parked until its own cycle
          next_req = 1'b1;
          next_wr_n = cmd_write ? WR_N_WRITE : ~WR_N_WRITE;
          next_sa = {cmd_sel, 1'b0};
          next_wdata = cmd_wdata[7:0];
          next_hi_hold = cmd_wdata[15:8];
          next_ready = 1'b0;
          next_state = ST_LO_WAIT;
        end
      end
      ST_LO_WAIT: begin
        if (port.io_ack) begin
          next_lo_read = port.rdata;
          next_req = 1'b1;
          next_sa = {sa[SA_W-1:1], 1'b1};
          next_wdata = hi_hold;
          next_state = ST_HI_WAIT;
        end
      end
      ST_HI_WAIT: begin
        if (port.io_ack) begin
          next_rword = {port.rdata, lo_read};
          next_rvalid = 1'b1;
          next_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_ready = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      req <= 1'b0;
      wr_n <= ~WR_N_WRITE;
      sa <= '0;
      wdata <= BYTE_RESET;
      hi_hold <= BYTE_RESET;
      lo_read <= BYTE_RESET;
      ready <= 1'b1;
      rvalid <= 1'b0;
      rword <= MEM_RESET;
    end else begin
      state <= next_state;
      req <= next_req;
      wr_n <= next_wr_n;
      sa <= next_sa;
      wdata <= next_wdata;
      hi_hold <= next_hi_hold;
      lo_read <= next_lo_read;
      ready <= next_ready;
      rvalid <= next_rvalid;
      rword <= next_rword;
    end
  end

  assign port.io_req = req;
  assign port.io_wr_n = wr_n;
  assign port.sa = sa;
  assign port.wdata = wdata;
  assign cmd_ready = ready;
  assign resp_valid = rvalid;
  assign resp_data = rword;

endmodule : ihb_host_end

`default_nettype wire

// ===== testbench/ihb_window_sva.sv
// Checker for the byte-wide I/O window between the two ends
`timescale 1ns/1ps
`default_nettype none

module ihb_window_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic io_req,
  input wire logic io_wr_n,
  input wire logic [ihb_pkg::SA_W-1:0] sa,
  input wire logic [ihb_pkg::BYTE_W-1:0] wdata,
  input wire logic io_ack,
  input wire logic [ihb_pkg::BYTE_W-1:0] rdata
);
  import ihb_pkg::*;

  logic rd_take;
  assign rd_take = io_req & io_wr_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_ack_next: assert property (io_req |=> io_ack)
    else $error("byte cycle not acknowledged");
  a_ack_cause: assert property (io_ack |-> $past(io_req))
    else $error("acknowledge without a byte cycle");
  a_low_then_high: assert property (io_req && !sa[0] |-> ##2 io_req && sa[0])
    else $error("low byte not followed by high byte");
  a_high_after_low: assert property (io_req && sa[0] |-> $past(io_req, 2) && !$past(sa[0], 2))
    else $error("high byte without preceding low byte");
  a_pair_same_reg: assert property (io_req && sa[0] |-> sa[2:1] == $past(sa[2:1], 2))
    else $error("byte pair split over two registers");
  a_pair_same_dir: assert property (io_req && sa[0] |-> io_wr_n == $past(io_wr_n, 2))
    else $error("byte pair mixes read and write");
  a_byte_gap: assert property (io_req |=> !io_req)
    else $error("byte cycles closer than two clocks");
  a_rdata_hold: assert property (!$past(rd_take) |-> $stable(rdata))
    else $error("read byte changed without a read");

  c_read_high: cover property (io_req && io_wr_n && sa == 3'h3);
  c_write_inc: cover property (io_req && !io_wr_n && sa == 3'h3);
  c_ptr_write: cover property (io_req && !io_wr_n && sa[2:1] == SEL_POINTER);
endmodule : ihb_window_sva

`default_nettype wire

// ===== testbench/isa_to_host_port_bridge_bench.sv
// Self-checking bench joining host end and device end through the window
`timescale 1ns/1ps
`default_nettype none

module isa_to_host_port_bridge_bench;
  import ihb_pkg::*;

  typedef struct packed {
    logic w;
    ihb_sel_t s;
    logic [15:0] d;
    logic [15:0] er;
    logic [15:0] ep;
  } ihb_row_s;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  ihb_sel_t cmd_sel = SEL_CONTROL;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_ready;
  logic resp_valid;
  logic [15:0] resp_data;
  logic [MEM_IDX_W-1:0] core_rd_index = 4'h0;
  logic [15:0] core_rd_data;
  logic [15:0] control_word;
  logic [15:0] pointer_word;
  logic word_stored;
  logic [15:0] r;
  int fails = 0;
  int checks = 0;

  // Write rows leave er unused; pointer wraps through FFFF on the last pair
  ihb_row_s rows [12] = '{
    '{1'h1, SEL_CONTROL, 16'hA55A, 16'h0000, 16'h0000},
    '{1'h0, SEL_CONTROL, 16'h0000, 16'hA55A, 16'h0000},
    '{1'h1, SEL_POINTER, 16'h0003, 16'h0000, 16'h0003},
    '{1'h0, SEL_POINTER, 16'h0000, 16'h0003, 16'h0003},
    '{1'h1, SEL_DATA_INC, 16'h1234, 16'h0000, 16'h0004},
    '{1'h1, SEL_DATA_FIXED, 16'h5678, 16'h0000, 16'h0004},
    '{1'h0, SEL_DATA_FIXED, 16'h0000, 16'h5678, 16'h0004},
    '{1'h0, SEL_DATA_INC, 16'h0000, 16'h5678, 16'h0005},
    '{1'h1, SEL_POINTER, 16'hFFFF, 16'h0000, 16'hFFFF},
    '{1'h1, SEL_DATA_INC, 16'hBEEF, 16'h0000, 16'h0000},
    '{1'h0, SEL_DATA_FIXED, 16'h0000, 16'hBEEF, 16'h0000},
    '{1'h0, SEL_DATA_INC, 16'h0000, 16'hBEEF, 16'h0001}
  };

  ihb_if link ();

  ihb_host_end ihb_host_end_inst (.core_clk(core_clk), .rst(rst), .port(link.host),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
    .resp_data(resp_data));

  ihb_device_end ihb_device_end_inst (.core_clk(core_clk), .rst(rst), .port(link.dev),
    .core_rd_index(core_rd_index), .core_rd_data(core_rd_data),
    .control_word(control_word), .pointer_word(pointer_word), .word_stored(word_stored));

  ihb_window_sva ihb_window_sva_inst (.core_clk(core_clk), .rst(rst), .io_req(link.io_req),
    .io_wr_n(link.io_wr_n), .sa(link.sa), .wdata(link.wdata), .io_ack(link.io_ack),
    .rdata(link.rdata));

  always #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // Entered and left one small delay after a rising edge
  task automatic cmd(input logic w, input ihb_sel_t s, input logic [15:0] d,
                     output logic [15:0] rd);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_sel = s;
    cmd_wdata = d;
    // Ready and response are looked at where they are settled, never at the launching edge
    while (cmd_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge core_clk);
      #1;
    end
    if (n >= 20) fails++;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 20) fails++;
    rd = resp_data;
  endtask : cmd

  task automatic do_reset;
    rst = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 rst = 1'b0;
    chk(control_word, CONTROL_RESET);
    chk(pointer_word, POINTER_RESET);
    chk({14'h0000, cmd_ready, link.io_wr_n}, 16'h0003);
  endtask : do_reset

  initial begin
    #20000;
    fails++;
    report_and_stop();
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      cmd(rows[i].w, rows[i].s, rows[i].d, r);
      if (!rows[i].w) chk(r, rows[i].er);
      chk(pointer_word, rows[i].ep);
    end
    chk(control_word, 16'hA55A);
    core_rd_index = 4'h4;
    @(posedge core_clk);
    #1 chk(core_rd_data, 16'h5678);
    core_rd_index = 4'h0;
    @(posedge core_clk);
    #1 chk(core_rd_data, 16'hBEEF);
    // Pointer must not move between the two bytes of one word
    cmd(1'h1, SEL_POINTER, 16'h0007, r);
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_sel = SEL_DATA_INC;
    cmd_wdata = 16'hC3A5;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    // Low byte taken at the first edge, high byte at the third
    repeat (2) @(posedge core_clk);
    #1 chk(pointer_word, 16'h0007);
    chk({15'h0000, word_stored}, 16'h0000);
    @(posedge core_clk);
    #1 chk(pointer_word, 16'h0008);
    chk({15'h0000, word_stored}, 16'h0001);
    @(posedge core_clk);
    #1 chk({15'h0000, resp_valid}, 16'h0001);
    core_rd_index = 4'h8;
    @(posedge core_clk);
    #1 chk(core_rd_data, 16'hC3A5);
    do_reset();
    cmd(1'h0, SEL_POINTER, 16'h0000, r);
    chk(r, POINTER_RESET);
    report_and_stop();
  end
endmodule : isa_to_host_port_bridge_bench

`default_nettype wire
